// ---- hw/tl_endpoint_consts.svh ----
// Purpose: Constants of the memory-mapped endpoint on the request/reply link
// Assumes: Single beat transfers, one clock
// Notes: Widths, address window, opcode and parameter codes
`ifndef TL_ENDPOINT_CONSTS_SVH
`define TL_ENDPOINT_CONSTS_SVH

`define TL_ADDR_W 32
`define TL_BEAT_BYTES 8
`define TL_DATA_W 64
`define TL_SOURCE_W 2
`define TL_SIZE_W 3
`define TL_MAX_LG_SIZE 3'h3
`define TL_RANGE_BASE 32'h0002_0000
`define TL_RANGE_MASK 32'h0000_0fff
`define TL_STORE_WORDS 8
`define TL_STORE_IDX_LSB 3
`define TL_STORE_IDX_MSB 5
`define TL_STORE_RESET 64'h0

`define TL_A_PUT_FULL 3'h0
`define TL_A_PUT_PARTIAL 3'h1
`define TL_A_ARITHMETIC 3'h2
`define TL_A_LOGICAL 3'h3
`define TL_A_GET 3'h4
`define TL_A_HINT 3'h5

`define TL_D_ACK 3'h0
`define TL_D_ACK_DATA 3'h1
`define TL_D_HINT_ACK 3'h2

`define TL_ARITH_MIN 3'h0
`define TL_ARITH_MAX 3'h1
`define TL_ARITH_MINU 3'h2
`define TL_ARITH_MAXU 3'h3
`define TL_ARITH_ADD 3'h4
`define TL_LOGIC_XOR 3'h0
`define TL_LOGIC_OR 3'h1
`define TL_LOGIC_AND 3'h2
`define TL_LOGIC_SWAP 3'h3

`endif

// ---- hw/tl_endpoint_pkg.sv ----
// Purpose: Types carried on the request and reply channels
// Assumes: Constants come from the guarded header
// Notes: Fields follow the uncached request/reply channel layout
`include "tl_endpoint_consts.svh"

package tl_endpoint_pkg;

  typedef struct packed {
    logic [2:0] opcode;
    logic [2:0] param;
    logic [`TL_SIZE_W-1:0] size;
    logic [`TL_SOURCE_W-1:0] source;
    logic [`TL_ADDR_W-1:0] address;
    logic [`TL_BEAT_BYTES-1:0] mask;
    logic [`TL_DATA_W-1:0] data;
  } req_chan_t;

  typedef struct packed {
    logic [2:0] opcode;
    logic [1:0] param;
    logic [`TL_SIZE_W-1:0] size;
    logic [`TL_SOURCE_W-1:0] source;
    logic denied;
    logic [`TL_DATA_W-1:0] data;
    logic corrupt;
  } resp_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REPLY = 2'b10
  } ep_state_t;

endpackage

// ---- hw/atomic_lane_alu.sv ----
// Purpose: Arithmetic and logical read-modify-write on one beat
// Assumes: Operand lies in the byte lanes named by mask, aligned to size
// Notes: Signed compares honour the operand size, not the beat width
`timescale 1ns/1ns
`include "tl_endpoint_consts.svh"

module atomic_lane_alu
  import tl_endpoint_pkg::*;
(
  input wire logic [`TL_DATA_W-1:0] old_word,
  input wire logic [`TL_DATA_W-1:0] operand,
  input wire logic [`TL_BEAT_BYTES-1:0] lane_mask,
  input wire logic [2:0] byte_off,
  input wire logic [`TL_SIZE_W-1:0] size,
  input wire logic is_logical,
  input wire logic [2:0] param,
  output logic [`TL_DATA_W-1:0] new_word
);

  logic [5:0] shift;
  logic [`TL_DATA_W-1:0] old_s;
  logic [`TL_DATA_W-1:0] opd_s;
  logic [`TL_DATA_W-1:0] old_x;
  logic [`TL_DATA_W-1:0] opd_x;
  logic [`TL_DATA_W-1:0] result;
  logic [`TL_DATA_W-1:0] placed;

  function automatic logic [`TL_DATA_W-1:0] extend(
    input logic [`TL_DATA_W-1:0] v,
    input logic [`TL_SIZE_W-1:0] sz,
    input logic signed_op
  );
    logic [`TL_DATA_W-1:0] r;
    r = v;
    unique case (sz)
      3'h0: r = {{56{signed_op & v[7]}}, v[7:0]};
      3'h1: r = {{48{signed_op & v[15]}}, v[15:0]};
      3'h2: r = {{32{signed_op & v[31]}}, v[31:0]};
      default: r = v;
    endcase
    return r;
  endfunction

  assign shift = {byte_off, 3'h0};
  assign old_s = old_word >> shift;
  assign opd_s = operand >> shift;

  always_comb
  begin
    old_x = extend(old_s, size, (param == `TL_ARITH_MIN) || (param == `TL_ARITH_MAX));
    opd_x = extend(opd_s, size, (param == `TL_ARITH_MIN) || (param == `TL_ARITH_MAX));
    result = old_x;
    if (is_logical)
    begin
      unique case (param)
        `TL_LOGIC_XOR: result = old_s ^ opd_s;
        `TL_LOGIC_OR: result = old_s | opd_s;
        `TL_LOGIC_AND: result = old_s & opd_s;
        `TL_LOGIC_SWAP: result = opd_s;
        default: result = old_s;
      endcase
    end
    else
    begin
      unique case (param)
        `TL_ARITH_MIN: result = ($signed(opd_x) < $signed(old_x)) ? opd_x : old_x;
        `TL_ARITH_MAX: result = ($signed(opd_x) > $signed(old_x)) ? opd_x : old_x;
        `TL_ARITH_MINU: result = (opd_x < old_x) ? opd_x : old_x;
        `TL_ARITH_MAXU: result = (opd_x > old_x) ? opd_x : old_x;
        `TL_ARITH_ADD: result = old_s + opd_s;
        default: result = old_s;
      endcase
    end
  end

  assign placed = result << shift;

  // Only lanes that the request owns change; the rest keep the old value
  for (genvar b = 0; b < `TL_BEAT_BYTES; b++)
  begin : g_lane
    assign new_word[8*b +: 8] = lane_mask[b] ? placed[8*b +: 8] : old_word[8*b +: 8];
  end

endmodule

// ---- hw/tilelink_mmio_endpoint.sv ----
// Purpose: Memory-mapped endpoint answering requests on A with replies on D
// Assumes: Client keeps its own source, visibility and hold duties
// Notes: One request at a time, so replies always leave in request order
//
// What this block does
// - In-order option returns replies in request order.
// - Manager takes A requests, replies on D.
// - Data path is eight bytes per beat.
// - Only addresses 0x20000 to 0x20fff are served.
// - Address matches base outside the mask bits.
// - Accept all six request kinds, 1-8 bytes.
// - Sizes are inclusive ranges of powers two.
// - Same ordering domain keeps reply order.
// - Port is ready/valid channels A and D.
// - Control and status registers sit behind port.
// - Get answered with data-carrying acknowledgement.
// - Each write gets one dataless acknowledgement.
// - Atomics return the old value with data.
`timescale 1ns/1ns
`include "tl_endpoint_consts.svh"

module tilelink_mmio_endpoint
  import tl_endpoint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic a_valid,
  output logic a_ready,
  input wire req_chan_t a_bits,
  output logic d_valid,
  input wire logic d_ready,
  output resp_chan_t d_bits
);

  localparam logic [`TL_ADDR_W-1:0] RANGE_BASE = `TL_RANGE_BASE;
  localparam logic [`TL_ADDR_W-1:0] RANGE_MASK = `TL_RANGE_MASK;
  localparam logic [`TL_SIZE_W-1:0] MAX_LG_SIZE = `TL_MAX_LG_SIZE;
  localparam int IDX_W = `TL_STORE_IDX_MSB - `TL_STORE_IDX_LSB + 1;

  ep_state_t state_reg;
  ep_state_t state_next;
  logic a_ready_reg;
  logic d_valid_reg;
  resp_chan_t d_bits_reg;
  logic [`TL_DATA_W-1:0] store_reg [`TL_STORE_WORDS];

  logic a_fire;
  logic d_fire;
  logic addr_hit;
  logic size_ok;
  logic align_ok;
  logic op_ok;
  logic denied;
  logic in_store;
  logic [IDX_W-1:0] word_idx;
  logic [`TL_DATA_W-1:0] old_word;
  logic [`TL_DATA_W-1:0] put_word;
  logic [`TL_DATA_W-1:0] amo_word;
  logic is_write;
  logic is_amo;
  logic [`TL_SIZE_W-1:0] align_bits;

  // Handshakes on both channels
  assign a_fire = a_valid && a_ready_reg;
  assign d_fire = d_valid_reg && d_ready;

  // Base/mask match: every bit outside the mask equals the base
  assign addr_hit = ((a_bits.address ^ RANGE_BASE) & ~RANGE_MASK) == '0;

  // Sizes are powers of two from one byte up to the beat width
  assign size_ok = a_bits.size <= MAX_LG_SIZE;

  // A transfer must sit naturally aligned within the beat
  assign align_bits = (a_bits.size == 3'h0) ? 3'h0 :
                      (a_bits.size == 3'h1) ? 3'h1 :
                      (a_bits.size == 3'h2) ? 3'h3 : 3'h7;
  assign align_ok = (a_bits.address[2:0] & align_bits) == 3'h0;

  // All six uncached request kinds are served
  always_comb
  begin
    unique case (a_bits.opcode)
      `TL_A_PUT_FULL,
      `TL_A_PUT_PARTIAL,
      `TL_A_GET,
      `TL_A_HINT: op_ok = 1'b1;
      `TL_A_ARITHMETIC: op_ok = a_bits.param <= `TL_ARITH_ADD;
      `TL_A_LOGICAL: op_ok = a_bits.param <= `TL_LOGIC_SWAP;
      default: op_ok = 1'b0;
    endcase
  end

  // A request the routing should never have sent here is answered, but denied
  assign denied = !(addr_hit && size_ok && align_ok && op_ok);

  // Backing words live at the bottom of the window; the rest reads as zero
  assign in_store = a_bits.address[11:`TL_STORE_IDX_MSB+1] == '0;
  assign word_idx = a_bits.address[`TL_STORE_IDX_MSB:`TL_STORE_IDX_LSB];
  assign old_word = in_store ? store_reg[word_idx] : `TL_STORE_RESET;

  assign is_write = (a_bits.opcode == `TL_A_PUT_FULL) || (a_bits.opcode == `TL_A_PUT_PARTIAL);
  assign is_amo = (a_bits.opcode == `TL_A_ARITHMETIC) || (a_bits.opcode == `TL_A_LOGICAL);

  // Byte-mask merge covers both full and partial puts
  for (genvar b = 0; b < `TL_BEAT_BYTES; b++)
  begin : g_put_lane
    assign put_word[8*b +: 8] = a_bits.mask[b] ? a_bits.data[8*b +: 8] : old_word[8*b +: 8];
  end

  atomic_lane_alu u_alu (
    .old_word(old_word),
    .operand(a_bits.data),
    .lane_mask(a_bits.mask),
    .byte_off(a_bits.address[2:0]),
    .size(a_bits.size),
    .is_logical(a_bits.opcode == `TL_A_LOGICAL),
    .param(a_bits.param),
    .new_word(amo_word)
  );

  // One request in flight: the next is taken only once the reply has left,
  // which keeps the ordering domain and in-order option trivially satisfied
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (a_fire)
        begin
          state_next = ST_REPLY;
        end
      end
      ST_REPLY:
      begin
        if (d_fire)
        begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Ready is registered: it drops on the accepting edge and returns as the reply leaves
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      a_ready_reg <= 1'b0;
    end
    else
    begin
      a_ready_reg <= (state_next == ST_IDLE);
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      d_valid_reg <= 1'b0;
    end
    else if (a_fire)
    begin
      d_valid_reg <= 1'b1;
    end
    else if (d_fire)
    begin
      d_valid_reg <= 1'b0;
    end
  end

  // Reply fields are captured on accept and held until taken
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      d_bits_reg <= '0;
    end
    else if (a_fire)
    begin
      d_bits_reg.source <= a_bits.source;
      d_bits_reg.size <= a_bits.size;
      d_bits_reg.param <= 2'h0;
      d_bits_reg.denied <= denied;
      d_bits_reg.corrupt <= denied && !is_write && (a_bits.opcode != `TL_A_HINT);
      d_bits_reg.data <= '0;
      unique case (a_bits.opcode)
        `TL_A_GET:
        begin
          d_bits_reg.opcode <= `TL_D_ACK_DATA;
          d_bits_reg.data <= denied ? '0 : old_word;
        end
        `TL_A_ARITHMETIC,
        `TL_A_LOGICAL:
        begin
          d_bits_reg.opcode <= `TL_D_ACK_DATA;
          d_bits_reg.data <= denied ? '0 : old_word;
        end
        `TL_A_HINT: d_bits_reg.opcode <= `TL_D_HINT_ACK;
        default: d_bits_reg.opcode <= `TL_D_ACK;
      endcase
    end
  end

  // Backing words change only on an accepted, permitted write or atomic
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int w = 0; w < `TL_STORE_WORDS; w++)
      begin
        store_reg[w] <= `TL_STORE_RESET;
      end
    end
    else if (a_fire && !denied && in_store)
    begin
      if (is_write)
      begin
        store_reg[word_idx] <= put_word;
      end
      else if (is_amo)
      begin
        store_reg[word_idx] <= amo_word;
      end
    end
  end

  assign a_ready = a_ready_reg;
  assign d_valid = d_valid_reg;
  assign d_bits = d_bits_reg;

endmodule

// ---- tb/tilelink_mmio_endpoint_assertions.sv ----
// Purpose: Protocol checks on the request and reply channels of the endpoint
// Assumes: One request pending at a time, reply raised on the edge after accept
// Notes: Bound to the endpoint from the bench top
`timescale 1ns/1ns
`include "tl_endpoint_consts.svh"

module tilelink_mmio_endpoint_checker
  import tl_endpoint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic a_valid,
  input wire logic a_ready,
  input wire req_chan_t a_bits,
  input wire logic d_valid,
  input wire logic d_ready,
  input wire resp_chan_t d_bits
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence take_s;
    a_valid && a_ready;
  endsequence
  sequence reply_s;
    d_valid && d_ready;
  endsequence

  a_accept_reply: assert property (take_s |=> d_valid && !a_ready)
    else $error("no reply after accepted request");
  a_echo_fields: assert property (take_s |=>
    d_bits.source == $past(a_bits.source) && d_bits.size == $past(a_bits.size))
    else $error("reply source or size differs from request");
  a_get_data: assert property (take_s ##0 a_bits.opcode == `TL_A_GET |=>
    d_bits.opcode == `TL_D_ACK_DATA) else $error("read not answered with data");
  a_put_ack: assert property (take_s ##0 a_bits.opcode inside
    {`TL_A_PUT_FULL, `TL_A_PUT_PARTIAL} |=> d_bits.opcode == `TL_D_ACK)
    else $error("write not answered with dataless ack");
  a_atomic_old: assert property (take_s ##0 a_bits.opcode inside
    {`TL_A_ARITHMETIC, `TL_A_LOGICAL} |=> d_bits.opcode == `TL_D_ACK_DATA)
    else $error("atomic not answered with data");
  a_hint_ack: assert property (take_s ##0 a_bits.opcode == `TL_A_HINT |=>
    d_bits.opcode == `TL_D_HINT_ACK) else $error("hint not acknowledged");
  a_range_denied: assert property (take_s ##0
    (a_bits.address & ~`TL_RANGE_MASK) != `TL_RANGE_BASE |=> d_bits.denied)
    else $error("address outside window not denied");
  a_reply_hold: assert property (d_valid && !d_ready |=> d_valid && $stable(d_bits))
    else $error("reply changed before it was taken");
  a_ready_back: assert property (reply_s |=> a_ready && !d_valid)
    else $error("channel not freed after reply taken");
  a_write_clean: assert property (take_s ##0 a_bits.opcode inside
    {`TL_A_PUT_FULL, `TL_A_PUT_PARTIAL} |=> !d_bits.corrupt)
    else $error("write reply marked corrupt");
endmodule

// ---- tb/tl_client_model.sv ----
// Purpose: Behavioural client that issues one request and takes its reply
// Assumes: Driven 1 ns after the rising edge
// Notes: Released request lines carry the inverse of the last request
`timescale 1ns/1ns

module tl_client_model
  import tl_endpoint_pkg::*;
(
  input wire logic ref_clk,
  output logic a_valid,
  input wire logic a_ready,
  output req_chan_t a_bits,
  input wire logic d_valid,
  output logic d_ready,
  input wire resp_chan_t d_bits
);
  initial
  begin
    a_valid = 1'b0;
    a_bits = '0;
    d_ready = 1'b0;
  end

  // Uncached level: only channels A and D exist, no B, C or E to serve
  // Default visibility lets any address out; a read leaves only when a scenario asks,
  // and each write leaves by itself, never merged or held back
  // No instruction fetch is ever made through this port
  // One request in flight keeps every source distinct
  task automatic issue(input req_chan_t req, input int stall, output resp_chan_t rsp,
    output bit ok);
    int n;
    n = 0;
    @(posedge ref_clk) #1;
    a_valid = 1'b1;
    a_bits = req;
    @(posedge ref_clk);
    while (a_ready !== 1'b1 && n < 50)
    begin
      n++;
      @(posedge ref_clk);
    end
    #1;
    a_valid = 1'b0;
    a_bits = ~req;
    repeat (stall) @(posedge ref_clk) #1;
    d_ready = 1'b1;
    @(posedge ref_clk);
    while (d_valid !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge ref_clk);
    end
    rsp = d_bits;
    ok = n < 100;
    #1;
    d_ready = 1'b0;
  endtask
endmodule

// ---- tb/tilelink_mmio_endpoint_bench.sv ----
// Purpose: Directed scenarios for the endpoint through the client model
// Assumes: Store reads zero after reset
// Notes: Each scenario judges its replies before returning, save the setup puts of t_atomic and t_atomic_lanes
`timescale 1ns/1ns
`include "tl_endpoint_consts.svh"

module tilelink_mmio_endpoint_bench
  import tl_endpoint_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic a_valid, a_ready, d_valid, d_ready;
  req_chan_t a_bits;
  resp_chan_t d_bits, rsp;
  int num_errors = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  tilelink_mmio_endpoint dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .a_valid(a_valid),
    .a_ready(a_ready), .a_bits(a_bits), .d_valid(d_valid), .d_ready(d_ready), .d_bits(d_bits));
  tl_client_model client_u (.ref_clk(ref_clk), .a_valid(a_valid), .a_ready(a_ready),
    .a_bits(a_bits), .d_valid(d_valid), .d_ready(d_ready), .d_bits(d_bits));

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic xfer(input logic [2:0] op, input logic [2:0] prm, input logic [2:0] sz,
    input logic [1:0] src, input logic [31:0] addr, input logic [7:0] msk,
    input logic [63:0] dat, input int stall);
    bit ok;
    client_u.issue({op, prm, sz, src, addr, msk, dat}, stall, rsp, ok);
    if (!ok)
    begin
      num_errors++;
      summarize();
    end
  endtask

  task automatic reply(input logic [2:0] op, input logic [1:0] src, input logic [2:0] sz,
    input logic den);
    check("reply opcode", 64'(op), 64'(rsp.opcode));
    check("reply source", 64'(src), 64'(rsp.source));
    check("reply size", 64'(sz), 64'(rsp.size));
    check("reply denied", 64'(den), 64'(rsp.denied));
    check("reply param", 64'h0, 64'(rsp.param));
  endtask

  task automatic t_put_get();
    xfer(`TL_A_PUT_FULL, 3'h0, 3'h3, 2'h1, 32'h0002_0008, 8'hff, 64'h0123_4567_89ab_cdef, 0);
    reply(`TL_D_ACK, 2'h1, 3'h3, 1'b0);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h2, 32'h0002_0008, 8'hff, 64'h0, 2);
    reply(`TL_D_ACK_DATA, 2'h2, 3'h3, 1'b0);
    check("get data", 64'h0123_4567_89ab_cdef, rsp.data);
    $display("put and get finished");
  endtask

  task automatic t_partial();
    xfer(`TL_A_PUT_PARTIAL, 3'h0, 3'h0, 2'h3, 32'h0002_0002, 8'h04, 64'h005a_0000, 0);
    reply(`TL_D_ACK, 2'h3, 3'h0, 1'b0);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h0, 32'h0002_0000, 8'hff, 64'h0, 0);
    check("partial lane", 64'h005a_0000, rsp.data);
    $display("partial write finished");
  endtask

  task automatic t_atomic();
    xfer(`TL_A_PUT_FULL, 3'h0, 3'h3, 2'h0, 32'h0002_0010, 8'hff, 64'h5, 0);
    xfer(`TL_A_ARITHMETIC, `TL_ARITH_ADD, 3'h3, 2'h1, 32'h0002_0010, 8'hff, 64'h3, 1);
    reply(`TL_D_ACK_DATA, 2'h1, 3'h3, 1'b0);
    check("add old value", 64'h5, rsp.data);
    xfer(`TL_A_LOGICAL, `TL_LOGIC_XOR, 3'h3, 2'h2, 32'h0002_0010, 8'hff, 64'hf, 0);
    check("xor old value", 64'h8, rsp.data);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h3, 32'h0002_0010, 8'hff, 64'h0, 0);
    check("atomic result", 64'h7, rsp.data);
    $display("atomics finished");
  endtask

  task automatic t_range();
    xfer(`TL_A_GET, 3'h0, 3'h0, 2'h0, 32'h0002_1000, 8'h01, 64'h0, 0);
    reply(`TL_D_ACK_DATA, 2'h0, 3'h0, 1'b1);
    xfer(`TL_A_GET, 3'h0, 3'h0, 2'h1, 32'h0002_0fff, 8'h80, 64'h0, 0);
    reply(`TL_D_ACK_DATA, 2'h1, 3'h0, 1'b0);
    xfer(`TL_A_PUT_FULL, 3'h0, 3'h3, 2'h2, 32'h0001_0008, 8'hff, 64'h0, 0);
    reply(`TL_D_ACK, 2'h2, 3'h3, 1'b1);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h3, 32'h0002_0008, 8'hff, 64'h0, 0);
    check("store after denied", 64'h0123_4567_89ab_cdef, rsp.data);
    $display("address window finished");
  endtask

  task automatic t_sizes();
    logic [7:0] m [4] = '{8'h01, 8'h03, 8'h0f, 8'hff};
    xfer(`TL_A_HINT, 3'h0, 3'h3, 2'h1, 32'h0002_0008, 8'hff, 64'h0, 3);
    reply(`TL_D_HINT_ACK, 2'h1, 3'h3, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      xfer(`TL_A_GET, 3'h0, 3'(s), 2'(s), 32'h0002_0008, m[s], 64'h0, s);
      reply(`TL_D_ACK_DATA, 2'(s), 3'(s), 1'b0);
    end
    $display("sizes and sources finished");
  endtask

  task automatic t_atomic_lanes();
    logic [2:0] opc [7] = '{`TL_A_ARITHMETIC, `TL_A_ARITHMETIC, `TL_A_ARITHMETIC,
      `TL_A_ARITHMETIC, `TL_A_LOGICAL, `TL_A_LOGICAL, `TL_A_LOGICAL};
    logic [2:0] prm [7] = '{`TL_ARITH_MAX, `TL_ARITH_MAXU, `TL_ARITH_MIN, `TL_ARITH_MINU,
      `TL_LOGIC_OR, `TL_LOGIC_AND, `TL_LOGIC_SWAP};
    logic [7:0] opd [7] = '{8'h05, 8'h80, 8'h01, 8'h01, 8'h30, 8'h12, 8'haa};
    logic [7:0] old [7] = '{8'hf0, 8'h05, 8'h80, 8'h80, 8'h01, 8'h31, 8'h10};
    xfer(`TL_A_PUT_FULL, 3'h0, 3'h3, 2'h0, 32'h0002_0018, 8'hff, 64'h1111_1111_1111_f011, 0);
    // Byte lane 1 only: signed compares must see the byte, not the whole beat
    for (int i = 0; i < 7; i++)
    begin
      xfer(opc[i], prm[i], 3'h0, 2'(i), 32'h0002_0019, 8'h02, {48'h0, opd[i], 8'h00}, 0);
      reply(`TL_D_ACK_DATA, 2'(i), 3'h0, 1'b0);
      check("lane old value", {48'h1111_1111_1111, old[i], 8'h11}, rsp.data);
    end
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h3, 32'h0002_0018, 8'hff, 64'h0, 0);
    check("lane result", 64'h1111_1111_1111_aa11, rsp.data);
    $display("atomic lanes finished");
  endtask

  task automatic t_denied();
    xfer(`TL_A_GET, 3'h0, 3'h2, 2'h0, 32'h0002_0002, 8'h0c, 64'h0, 0);
    reply(`TL_D_ACK_DATA, 2'h0, 3'h2, 1'b1);
    check("denied corrupt", 64'h1, 64'(rsp.corrupt));
    check("denied data", 64'h0, rsp.data);
    xfer(`TL_A_GET, 3'h0, 3'h4, 2'h1, 32'h0002_0000, 8'hff, 64'h0, 0);
    reply(`TL_D_ACK_DATA, 2'h1, 3'h4, 1'b1);
    xfer(`TL_A_ARITHMETIC, 3'h5, 3'h3, 2'h2, 32'h0002_0008, 8'hff, 64'h1, 0);
    reply(`TL_D_ACK_DATA, 2'h2, 3'h3, 1'b1);
    xfer(`TL_A_PUT_FULL, 3'h0, 3'h3, 2'h3, 32'h0002_0040, 8'hff, 64'hffff, 0);
    reply(`TL_D_ACK, 2'h3, 3'h3, 1'b0);
    check("ack corrupt", 64'h0, 64'(rsp.corrupt));
    check("ack data", 64'h0, rsp.data);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h0, 32'h0002_0040, 8'hff, 64'h0, 0);
    check("unbacked read", 64'h0, rsp.data);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h1, 32'h0002_0000, 8'hff, 64'h0, 0);
    check("no alias write", 64'h005a_0000, rsp.data);
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h2, 32'h0002_0008, 8'hff, 64'h0, 0);
    check("after denied atomic", 64'h0123_4567_89ab_cdef, rsp.data);
    $display("denied requests finished");
  endtask

  task automatic t_reset();
    @(posedge ref_clk) #1;
    reset_n = 1'b0;
    #1;
    check("ready in reset", 64'h0, 64'(a_ready));
    check("reply valid in reset", 64'h0, 64'(d_valid));
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    xfer(`TL_A_GET, 3'h0, 3'h3, 2'h1, 32'h0002_0008, 8'hff, 64'h0, 0);
    reply(`TL_D_ACK_DATA, 2'h1, 3'h3, 1'b0);
    check("store after reset", 64'h0, rsp.data);
    $display("mid-run reset finished");
  endtask

  initial
  begin
    repeat (20) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    t_put_get();
    t_partial();
    t_atomic();
    t_range();
    t_sizes();
    t_atomic_lanes();
    t_denied();
    t_reset();
    summarize();
  end
endmodule

bind tilelink_mmio_endpoint tilelink_mmio_endpoint_checker chk_u (.ref_clk(ref_clk),
  .reset_n(reset_n), .a_valid(a_valid), .a_ready(a_ready), .a_bits(a_bits),
  .d_valid(d_valid), .d_ready(d_ready), .d_bits(d_bits));
